// file: shared/pmc_pkg.sv
// constants and types for the port mode control block
package pmc_pkg;

    localparam int PORT_A = 0;
    localparam int PORT_B = 1;
    localparam int PORT_C = 2;
    localparam int PORT_D = 3;
    localparam int NPORT  = 4;
    localparam int PW     = 8;

    // register offsets from the io_register_space base
    localparam logic [3:0] OFF_MODE_A = 4'h0;
    localparam logic [3:0] OFF_MODE_B = 4'h1;
    localparam logic [3:0] OFF_DIR_A  = 4'h2;
    localparam logic [3:0] OFF_DIR_B  = 4'h3;
    localparam logic [3:0] OFF_DIR_C  = 4'h4;
    localparam logic [3:0] OFF_DIR_D  = 4'h5;
    localparam logic [3:0] OFF_DRV_A  = 4'h6;
    localparam logic [3:0] OFF_DRV_B  = 4'h7;
    localparam logic [3:0] OFF_DRV_C  = 4'h8;
    localparam logic [3:0] OFF_DRV_D  = 4'h9;

    localparam logic [7:0] REG_RESET   = 8'h00;
    localparam logic [7:0] READ_UNMAP  = 8'h00;
    localparam logic [7:0] PORT_D_MASK = 8'h07;
    localparam logic [7:0] SCAN_PINS   = 8'h0F;

    typedef logic [NPORT-1:0][PW-1:0] pmc_ports_t;

    // drive-type bits that select open drain, per port (D..A)
    localparam pmc_ports_t OD_CAPABLE = {8'h00, 8'hFF, 8'hF0, 8'hF0};

    // programmed bus type, gray ordered
    typedef enum logic [1:0] {
        BUS_MUX_GENERIC = 2'b00,
        BUS_MUX_PARTIAL = 2'b01,
        BUS_MUX_PAGED   = 2'b11,
        BUS_NONMUX      = 2'b10
    } pmc_bus_t;

    typedef struct packed {
        logic [1:0][PW-1:0] mode;
        pmc_ports_t         dir;
        pmc_ports_t         drv;
        logic [15:0]        alat;
        pmc_ports_t         ain;
        pmc_ports_t         pin;
        pmc_ports_t         oe_n;
        pmc_ports_t         din;
        logic [PW-1:0]      rdata;
        logic [PW-1:0]      ext_rdata;
        logic               scan;
    } pmc_state_t;

endpackage

// file: hdl/pmc_port_mode_control.sv
// port mode control: configuration registers and per-pin output muxing
// Overview of operation
// - mode bit 0 on A/B gives MCU I/O
// - MCU I/O drives data-out, reads data-in
// - output enable is direction OR array term
// - direction 1 output, 0 input, default input
// - ports C, D have no mode register
// - logic array I/O uses macrocell, tri-state otherwise
// - address out needs term or direction and mode
// - latched address nibbles mapped by bus type
// - non-multiplexed bus drives address 7:0 on B
// - upper address inputs latched by address strobe
// - data port mode gives port A to bus
// - peripheral bit turns port A into buffer
// - buffer tri-stated without a peripheral select
// - scan pins on port C, three enables
// - register bit n controls pin n
// - all configuration registers reset to zero
// - registers reached by ordinary bus cycles
// - programmed modes are inputs, others registers
// - mode availability differs per port
// - mode bit 1 selects address out
`timescale 1ns/1ns
`default_nettype none
module pmc_port_mode_control (
    // clock and reset
    input  wire logic              ref_clk_i,
    input  wire logic              rst_n_i,
    // register access in io_register_space
    input  wire logic              io_sel_i,
    input  wire logic [3:0]        reg_off_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    input  wire logic [7:0]        reg_wdata_i,
    output logic [7:0]             reg_rdata_o,
    // programmed configuration
    input  wire pmc_pkg::pmc_bus_t bus_type_i,
    input  wire logic              data_port_en_i,
    input  wire logic              peripheral_io_enable_bit_i,
    input  wire pmc_pkg::pmc_ports_t logic_array_io_mode_i,
    input  wire pmc_pkg::pmc_ports_t addr_in_sel_i,
    input  wire logic              scan_cfg_i,
    // logic array terms
    input  wire pmc_pkg::pmc_ports_t oe_term_i,
    input  wire pmc_pkg::pmc_ports_t macrocell_out_i,
    input  wire logic              peripheral_select_0_i,
    input  wire logic              peripheral_select_1_i,
    input  wire logic              scan_port_select_term_i,
    input  wire logic              scan_en_i,
    // microcontroller bus
    input  wire logic [15:0]       addr_i,
    input  wire logic              address_strobe_i,
    input  wire logic [7:0]        ext_data_i,
    input  wire logic              ext_wr_i,
    input  wire logic              ext_rd_i,
    input  wire logic [7:0]        core_rdata_i,
    output logic [7:0]             ext_rdata_o,
    // port data and pins
    input  wire pmc_pkg::pmc_ports_t data_out_i,
    input  wire pmc_pkg::pmc_ports_t pin_i,
    output pmc_pkg::pmc_ports_t    pin_o,
    output pmc_pkg::pmc_ports_t    pin_oe_n_o,
    // observed state
    output pmc_pkg::pmc_ports_t    data_in_o,
    output pmc_pkg::pmc_ports_t    addr_in_o,
    output logic                   scan_active_o
);
    import pmc_pkg::*;

    pmc_state_t st_r;
    pmc_state_t st_nxt;
    pmc_ports_t addr_v;
    pmc_ports_t avail;
    pmc_ports_t pv;
    pmc_ports_t pe;

    // latched address placement for ports A and B
    always_comb begin
        addr_v = '0;
        avail  = '0;
        case (bus_type_i)
            BUS_MUX_GENERIC: begin
                addr_v[PORT_A] = st_r.alat[7:0];
                addr_v[PORT_B] = st_r.alat[7:0];
                avail[PORT_A]  = 8'hFF;
                avail[PORT_B]  = 8'hFF;
            end
            BUS_MUX_PARTIAL: begin
                addr_v[PORT_A] = {st_r.alat[7:4], 4'h0};
                addr_v[PORT_B] = {4'h0, st_r.alat[11:8]};
                avail[PORT_A]  = 8'hF0;
                avail[PORT_B]  = 8'h0F;
            end
            BUS_MUX_PAGED: begin
                addr_v[PORT_B] = st_r.alat[15:8];
                avail[PORT_B]  = 8'hFF;
            end
            BUS_NONMUX: begin
                addr_v[PORT_B] = st_r.alat[7:0];
                avail[PORT_B]  = 8'hFF;
            end
            default: begin
                addr_v = '0;
                avail  = '0;
            end
        endcase
    end

    // per-pin output mux and driver enable
    genvar gp, gb;
    generate
        for (gp = 0; gp < NPORT; gp++) begin : g_port
            for (gb = 0; gb < PW; gb++) begin : g_bit
                logic ctl;
                logic drive_en;
                logic amode;
                logic val;
                logic od;
                if (gp < 2) begin : g_mode
                    assign ctl = st_r.mode[gp][gb];
                end else begin : g_nomode
                    assign ctl = 1'b0;
                end
                assign drive_en = st_r.dir[gp][gb] | oe_term_i[gp][gb];
                assign amode    = avail[gp][gb] & ctl & drive_en;
                assign val      = logic_array_io_mode_i[gp][gb] ? macrocell_out_i[gp][gb] :
                                  amode ? addr_v[gp][gb] : data_out_i[gp][gb];
                assign od       = OD_CAPABLE[gp][gb] & st_r.drv[gp][gb];
                // open drain only pulls low
                assign pe[gp][gb] = drive_en & ~(od & val);
                assign pv[gp][gb] = val;
            end
        end
    endgenerate

    always_comb begin
        st_nxt = st_r;
        // register writes
        if (io_sel_i && reg_wr_i) begin
            case (reg_off_i)
                OFF_MODE_A: st_nxt.mode[PORT_A] = reg_wdata_i;
                OFF_MODE_B: st_nxt.mode[PORT_B] = reg_wdata_i;
                OFF_DIR_A:  st_nxt.dir[PORT_A]  = reg_wdata_i;
                OFF_DIR_B:  st_nxt.dir[PORT_B]  = reg_wdata_i;
                OFF_DIR_C:  st_nxt.dir[PORT_C]  = reg_wdata_i;
                OFF_DIR_D:  st_nxt.dir[PORT_D]  = reg_wdata_i & PORT_D_MASK;
                OFF_DRV_A:  st_nxt.drv[PORT_A]  = reg_wdata_i;
                OFF_DRV_B:  st_nxt.drv[PORT_B]  = reg_wdata_i;
                OFF_DRV_C:  st_nxt.drv[PORT_C]  = reg_wdata_i;
                OFF_DRV_D:  st_nxt.drv[PORT_D]  = reg_wdata_i & PORT_D_MASK;
                default:    st_nxt.dir          = st_r.dir;
            endcase
        end
        // register reads, answered one cycle later
        if (io_sel_i && reg_rd_i) begin
            case (reg_off_i)
                OFF_MODE_A: st_nxt.rdata = st_r.mode[PORT_A];
                OFF_MODE_B: st_nxt.rdata = st_r.mode[PORT_B];
                OFF_DIR_A:  st_nxt.rdata = st_r.dir[PORT_A];
                OFF_DIR_B:  st_nxt.rdata = st_r.dir[PORT_B];
                OFF_DIR_C:  st_nxt.rdata = st_r.dir[PORT_C];
                OFF_DIR_D:  st_nxt.rdata = st_r.dir[PORT_D] & PORT_D_MASK;
                OFF_DRV_A:  st_nxt.rdata = st_r.drv[PORT_A];
                OFF_DRV_B:  st_nxt.rdata = st_r.drv[PORT_B];
                OFF_DRV_C:  st_nxt.rdata = st_r.drv[PORT_C];
                OFF_DRV_D:  st_nxt.rdata = st_r.drv[PORT_D] & PORT_D_MASK;
                default:    st_nxt.rdata = READ_UNMAP;
            endcase
        end
        // address strobe is a clock enable for the address register
        if (address_strobe_i) begin
            st_nxt.alat = addr_i;
            st_nxt.ain  = (st_r.ain & ~addr_in_sel_i) | (pin_i & addr_in_sel_i);
        end
        st_nxt.pin = pv;
        st_nxt.oe_n = ~pe;
        if (data_port_en_i) begin
            st_nxt.pin[PORT_A]  = core_rdata_i;
            st_nxt.oe_n[PORT_A] = {PW{~ext_rd_i}};
        end else if (peripheral_io_enable_bit_i) begin
            st_nxt.pin[PORT_A]  = ext_data_i;
            st_nxt.oe_n[PORT_A] = {PW{~((peripheral_select_0_i | peripheral_select_1_i) & ext_wr_i)}};
        end
        st_nxt.scan = scan_port_select_term_i | scan_cfg_i | scan_en_i;
        if (st_nxt.scan) begin
            st_nxt.oe_n[PORT_C] = st_nxt.oe_n[PORT_C] | SCAN_PINS;
        end
        st_nxt.din       = pin_i;
        st_nxt.ext_rdata = pin_i[PORT_A];
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            st_r      <= '0;
            st_r.oe_n <= '1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata_o   = st_r.rdata;
    assign ext_rdata_o   = st_r.ext_rdata;
    assign pin_o         = st_r.pin;
    assign pin_oe_n_o    = st_r.oe_n;
    assign data_in_o     = st_r.din;
    assign addr_in_o     = st_r.ain;
    assign scan_active_o = st_r.scan;

    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_wr(logic [3:0] off);
        io_sel_i && reg_wr_i && reg_off_i == off;
    endsequence

    sequence s_rd(logic [3:0] off);
        io_sel_i && reg_rd_i && !reg_wr_i && reg_off_i == off;
    endsequence

    sequence s_plain_b0;
        !data_port_en_i && !logic_array_io_mode_i[PORT_B][0] && !st_r.mode[PORT_B][0];
    endsequence

    property p_reset_zero;
        disable iff (1'b0) !rst_n_i |=> st_r.mode == '0 && st_r.dir == '0 && st_r.drv == '0 && &pin_oe_n_o;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("config not zero after reset");

    property p_write_mode;
        s_wr(OFF_MODE_A) |=> st_r.mode[PORT_A] == $past(reg_wdata_i);
    endproperty
    a_write_mode: assert property (p_write_mode) else $error("mode write lost");

    property p_readback;
        s_wr(OFF_DIR_D) ##1 s_rd(OFF_DIR_D) |=> reg_rdata_o == ($past(reg_wdata_i, 2) & PORT_D_MASK);
    endproperty
    a_readback: assert property (p_readback) else $error("readback mismatch");

    property p_dir_drives;
        s_plain_b0 ##0 st_r.dir[PORT_B][0] |=> !pin_oe_n_o[PORT_B][0];
    endproperty
    a_dir_drives: assert property (p_dir_drives) else $error("output bit not driven");

    property p_mcu_out;
        s_plain_b0 ##0 st_r.dir[PORT_B][0] |=> pin_o[PORT_B][0] == $past(data_out_i[PORT_B][0]);
    endproperty
    a_mcu_out: assert property (p_mcu_out) else $error("data out not on pin");

    property p_logic_tri;
        !data_port_en_i && logic_array_io_mode_i[PORT_B][1] && !oe_term_i[PORT_B][1] && !st_r.dir[PORT_B][1]
            |=> pin_oe_n_o[PORT_B][1];
    endproperty
    a_logic_tri: assert property (p_logic_tri) else $error("array pin not tri-stated");

    property p_periph_tri;
        !data_port_en_i && peripheral_io_enable_bit_i && !peripheral_select_0_i && !peripheral_select_1_i
            |=> pin_oe_n_o[PORT_A] == 8'hFF;
    endproperty
    a_periph_tri: assert property (p_periph_tri) else $error("buffer not tri-stated");

    property p_periph_wr;
        !data_port_en_i && peripheral_io_enable_bit_i && peripheral_select_0_i && ext_wr_i
            |=> pin_o[PORT_A] == $past(ext_data_i) && pin_oe_n_o[PORT_A] == 8'h00;
    endproperty
    a_periph_wr: assert property (p_periph_wr) else $error("buffer write not driven");

    property p_paged_addr;
        bus_type_i == BUS_MUX_PAGED && st_r.mode[PORT_B] == 8'hFF && st_r.dir[PORT_B] == 8'hFF
            && logic_array_io_mode_i[PORT_B] == 8'h00 |=> pin_o[PORT_B] == $past(st_r.alat[15:8]);
    endproperty
    a_paged_addr: assert property (p_paged_addr) else $error("paged address misplaced");

    property p_scan;
        scan_en_i |=> scan_active_o && (pin_oe_n_o[PORT_C] & SCAN_PINS) == SCAN_PINS;
    endproperty
    a_scan: assert property (p_scan) else $error("scan pins not released");

    property p_data_port_idle;
        data_port_en_i && !ext_rd_i |=> pin_oe_n_o[PORT_A] == 8'hFF;
    endproperty
    a_data_port_idle: assert property (p_data_port_idle) else $error("data port driven while idle");

    property p_array_val;
        logic_array_io_mode_i[PORT_C][5] |=> pin_o[PORT_C][5] == $past(macrocell_out_i[PORT_C][5]);
    endproperty
    a_array_val: assert property (p_array_val) else $error("macrocell value not on pin");

    property p_dir_input;
        !st_r.dir[PORT_D][0] && !oe_term_i[PORT_D][0] |=> pin_oe_n_o[PORT_D][0];
    endproperty
    a_dir_input: assert property (p_dir_input) else $error("input pin driven");

    property p_port_c_mcu;
        !logic_array_io_mode_i[PORT_C][7] |=> pin_o[PORT_C][7] == $past(data_out_i[PORT_C][7]);
    endproperty
    a_port_c_mcu: assert property (p_port_c_mcu) else $error("port C pin not from data out");

    property p_addr_latch;
        address_strobe_i |=> st_r.alat == $past(addr_i);
    endproperty
    a_addr_latch: assert property (p_addr_latch) else $error("address not latched");

endmodule
`default_nettype wire

// file: test/pmc_mcu_model.sv
// microcontroller register bus model for the port mode control block
`timescale 1ns/1ns
`default_nettype none
module pmc_mcu_model (
    // clock
    input  wire logic       clk_i,
    // register bus toward the block
    output var logic        io_sel_o,
    output var logic [3:0]  reg_off_o,
    output var logic        reg_wr_o,
    output var logic        reg_rd_o,
    output var logic [7:0]  reg_wdata_o,
    input  wire logic [7:0] reg_rdata_i
);
    initial begin
        io_sel_o    = 1'b0;
        reg_off_o   = 4'h0;
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
        reg_wdata_o = 8'h00;
    end

    // callers boot first and never set direction on array input pins
    task automatic wr(input logic [3:0] off, input logic [7:0] d);
        @(negedge clk_i);
        io_sel_o    = 1'b1;
        reg_wr_o    = 1'b1;
        reg_off_o   = off;
        reg_wdata_o = d;
        @(negedge clk_i);
        io_sel_o    = 1'b0;
        reg_wr_o    = 1'b0;
        reg_wdata_o = ~d;
    endtask

    // data is taken half a cycle after the read edge
    task automatic rd(input logic [3:0] off, output logic [7:0] d);
        @(negedge clk_i);
        io_sel_o  = 1'b1;
        reg_rd_o  = 1'b1;
        reg_off_o = off;
        @(negedge clk_i);
        io_sel_o  = 1'b0;
        reg_rd_o  = 1'b0;
        d         = reg_rdata_i;
    endtask

    // write, then read in the very next cycle
    task automatic wr_rd(input logic [3:0] off, input logic [7:0] d, output logic [7:0] q);
        @(negedge clk_i);
        io_sel_o    = 1'b1;
        reg_wr_o    = 1'b1;
        reg_off_o   = off;
        reg_wdata_o = d;
        @(negedge clk_i);
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b1;
        @(negedge clk_i);
        io_sel_o    = 1'b0;
        reg_rd_o    = 1'b0;
        q           = reg_rdata_i;
    endtask
endmodule
`default_nettype wire

// file: test/pmc_port_mode_control_tb_top.sv
// self-checking testbench for the port mode control block
`timescale 1ns/1ns
`default_nettype none
module pmc_port_mode_control_tb_top;
    import pmc_pkg::*;
    logic       clk, rst_n, io_sel, wr, rd, dpe, pbuf, scfg, ps0, ps1, sst, sen, as, ewr, erd, scan_o;
    logic [3:0] off;
    logic [7:0] wd, rdat, ed, crd, erdat, v;
    logic [15:0] addr;
    pmc_bus_t   bt;
    pmc_ports_t lam, ais, oet, mco, dout, pin, po, poe, din, ain;
    int         bad_count, tests_run;

    always #20 clk = ~clk;

    pmc_mcu_model mcu (.clk_i(clk), .io_sel_o(io_sel), .reg_off_o(off), .reg_wr_o(wr), .reg_rd_o(rd),
        .reg_wdata_o(wd), .reg_rdata_i(rdat));

    pmc_port_mode_control uut (.ref_clk_i(clk), .rst_n_i(rst_n), .io_sel_i(io_sel), .reg_off_i(off),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wd), .reg_rdata_o(rdat), .bus_type_i(bt),
        .data_port_en_i(dpe), .peripheral_io_enable_bit_i(pbuf), .logic_array_io_mode_i(lam),
        .addr_in_sel_i(ais), .scan_cfg_i(scfg), .oe_term_i(oet), .macrocell_out_i(mco),
        .peripheral_select_0_i(ps0), .peripheral_select_1_i(ps1), .scan_port_select_term_i(sst),
        .scan_en_i(sen), .addr_i(addr), .address_strobe_i(as), .ext_data_i(ed), .ext_wr_i(ewr),
        .ext_rd_i(erd), .core_rdata_i(crd), .ext_rdata_o(erdat), .data_out_i(dout), .pin_i(pin),
        .pin_o(po), .pin_oe_n_o(poe), .data_in_o(din), .addr_in_o(ain), .scan_active_o(scan_o));

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic settle();
        repeat (3) @(negedge clk);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic t_reset();
        for (int i = 0; i < 16; i++) begin
            mcu.rd(i[3:0], v);
            chk("reset reg", v, 8'h00);
        end
        for (int p = 0; p < NPORT; p++) chk("reset oe_n", poe[p], 8'hFF);
    endtask

    task automatic t_regs();
        logic [7:0] e;
        for (int i = 0; i < 11; i++) mcu.wr(i[3:0], 8'hA0 + 8'(i));
        for (int i = 0; i < 11; i++) begin
            e = (i == 10) ? 8'h00 : 8'hA0 + 8'(i);
            if (i == 5 || i == 9) e = e & 8'h07;
            mcu.rd(i[3:0], v);
            chk("readback", v, e);
        end
        mcu.wr_rd(OFF_DIR_D, 8'hFE, v);
        chk("write then read", v, 8'h06);
        for (int i = 0; i < 10; i++) mcu.wr(i[3:0], 8'h00);
    endtask

    task automatic t_mcu_io();
        mcu.wr(OFF_DIR_A, 8'h05);
        oet[PORT_A] = 8'h30;
        dout[PORT_A] = 8'hAA;
        pin[PORT_B] = 8'h3C;
        settle();
        chk("oe_n A", poe[PORT_A], 8'hCA);
        chk("pin A", po[PORT_A] & 8'h35, 8'h20);
        chk("data in B", din[PORT_B], 8'h3C);
        mcu.wr(OFF_DRV_A, 8'hF0);
        settle();
        chk("open drain", poe[PORT_A], 8'hEA);
        mcu.wr(OFF_DRV_A, 8'h00);
        oet[PORT_A] = 8'h00;
        mcu.wr(OFF_DIR_A, 8'h00);
    endtask

    task automatic t_array();
        lam[PORT_C] = 8'hFF;
        lam[PORT_B] = 8'h02;
        mco[PORT_C] = 8'h5A;
        settle();
        chk("array off", poe[PORT_C], 8'hFF);
        chk("array off B", poe[PORT_B], 8'hFF);
        oet[PORT_C] = 8'h0F;
        settle();
        chk("array oe", poe[PORT_C], 8'hF0);
        chk("array val", po[PORT_C] & 8'h0F, 8'h0A);
        lam[PORT_C] = 8'h00;
        lam[PORT_B] = 8'h00;
        oet[PORT_C] = 8'h00;
    endtask

    task automatic t_addr_out();
        pmc_bus_t   bts[4] = '{BUS_MUX_GENERIC, BUS_MUX_PARTIAL, BUS_MUX_PAGED, BUS_NONMUX};
        logic [7:0] ea[4] = '{8'h21, 8'h29, 8'h99, 8'h99};
        logic [7:0] eb[4] = '{8'h21, 8'h63, 8'h43, 8'h21};
        mcu.wr(OFF_MODE_A, 8'hFF);
        mcu.wr(OFF_MODE_B, 8'hFF);
        mcu.wr(OFF_DIR_A, 8'hFF);
        mcu.wr(OFF_DIR_B, 8'hFF);
        dout[PORT_A] = 8'h99;
        dout[PORT_B] = 8'h66;
        addr = 16'h4321;
        as = 1'b1;
        for (int k = 0; k < 4; k++) begin
            bt = bts[k];
            settle();
            chk("addr A", po[PORT_A], ea[k]);
            chk("addr B", po[PORT_B], eb[k]);
        end
        bt = BUS_MUX_GENERIC;
        as = 1'b0;
        addr = 16'h8765;
        settle();
        chk("addr held", po[PORT_A], 8'h21);
        as = 1'b1;
        mcu.wr(OFF_DIR_A, 8'h00);
        settle();
        chk("no term", poe[PORT_A], 8'hFF);
        oet[PORT_A] = 8'hFF;
        settle();
        chk("term addr", po[PORT_A], 8'h65);
        mcu.wr(OFF_MODE_A, 8'h00);
        settle();
        chk("mode off", po[PORT_A], 8'h99);
        oet[PORT_A] = 8'h00;
        mcu.wr(OFF_MODE_B, 8'h00);
        mcu.wr(OFF_DIR_B, 8'h00);
    endtask

    task automatic t_data_port();
        mcu.wr(OFF_DIR_A, 8'hFF);
        dpe = 1'b1;
        crd = 8'hC3;
        erd = 1'b1;
        settle();
        chk("dp drive", poe[PORT_A], 8'h00);
        chk("dp data", po[PORT_A], 8'hC3);
        erd = 1'b0;
        pin[PORT_A] = 8'h5A;
        settle();
        chk("dp idle", poe[PORT_A], 8'hFF);
        chk("dp read", erdat, 8'h5A);
        dpe = 1'b0;
        pbuf = 1'b1;
        ed = 8'h3C;
        ewr = 1'b1;
        settle();
        chk("buffer idle", poe[PORT_A], 8'hFF);
        for (int s = 0; s < 2; s++) begin
            {ps1, ps0} = 2'b01 << s;
            settle();
            chk("buffer drive", poe[PORT_A], 8'h00);
            chk("buffer data", po[PORT_A], 8'h3C);
        end
        {ps1, ps0, ewr, pbuf} = 4'h0;
        mcu.wr(OFF_DIR_A, 8'h00);
    endtask

    task automatic t_scan();
        mcu.wr(OFF_DIR_C, 8'hFF);
        dout[PORT_C] = 8'hA5;
        for (int s = 0; s < 3; s++) begin
            {scfg, sst, sen} = 3'b100 >> s;
            settle();
            chk("scan on", {7'h00, scan_o}, 8'h01);
            chk("scan pins", poe[PORT_C], 8'h0F);
        end
        {scfg, sst, sen} = 3'b000;
        settle();
        chk("scan off", poe[PORT_C], 8'h00);
        chk("port C data", po[PORT_C], 8'hA5);
        dout[PORT_C] = 8'h00;
    endtask

    task automatic t_addr_in();
        ais[PORT_D] = 8'h07;
        pin[PORT_D] = 8'h05;
        settle();
        chk("addr in", ain[PORT_D] & 8'h07, 8'h05);
        as = 1'b0;
        pin[PORT_D] = 8'h02;
        settle();
        chk("addr hold", ain[PORT_D] & 8'h07, 8'h05);
        chk("data in D", din[PORT_D] & 8'h07, 8'h02);
    endtask

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        {dpe, pbuf, scfg, ps0, ps1, sst, sen, as, ewr, erd} = '0;
        {lam, ais, oet, mco, dout, pin} = '0;
        addr = 16'h0000;
        ed = 8'h00;
        crd = 8'h00;
        bt = BUS_MUX_GENERIC;
        bad_count = 0;
        tests_run = 0;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        t_reset();
        t_regs();
        t_mcu_io();
        t_array();
        t_addr_out();
        t_data_port();
        t_scan();
        t_addr_in();
        tally_and_finish();
    end

    // cuts a hang short
    initial begin
        #4000000;
        bad_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
